// ### rtl/adcs_top.sv
`timescale 1ns/10ps
`default_nettype none
// Sequencing and result buffering behind an AXI4-Lite slave.
module adcs_top #(
  parameter bit SECOND_INSTANCE = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axil_awaddr_i,
  input wire logic s_axil_awvalid_i,
  output logic s_axil_awready_o,
  input wire logic [31:0] s_axil_wdata_i,
  input wire logic [3:0] s_axil_wstrb_i,
  input wire logic s_axil_wvalid_i,
  output logic s_axil_wready_o,
  output logic [1:0] s_axil_bresp_o,
  output logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  input wire logic [7:0] s_axil_araddr_i,
  input wire logic s_axil_arvalid_i,
  output logic s_axil_arready_o,
  output logic [31:0] s_axil_rdata_o,
  output logic [1:0] s_axil_rresp_o,
  output logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  output logic conv_start_o,
  output adcs_pkg::adcs_route_t route_o,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_result_i,
  output logic [15:0] dma_addr_o,
  output logic dma_req_o,
  output logic irq_o
);

  // Byte-lane merge of a 16-bit register; upper lanes have no storage.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // First set position of the scan list at or after a start point, wrapping.
  function automatic logic [5:0] next_set(input logic [63:0] list, input logic [5:0] from);
    logic [5:0] idx;
    logic [5:0] res;
    logic found;
    res = from;
    found = 1'b0;
    for (int i = 0; i < 64; i++) begin
      idx = from + i[5:0];
      if (!found && list[idx]) begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  logic rst_meta; // First reset flop, read only by the second.
  logic rst_n; // Released reset used everywhere else.

  // Reset release through two flops so that release is clean against the clock.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Bus holding state.
  logic aw_got; // Write address captured.
  logic w_got; // Write data captured.
  logic [7:0] aw_addr; // Captured write address.
  logic [31:0] w_data; // Captured write data.
  logic [3:0] w_strb; // Captured byte enables.
  logic wr_fire; // Write performed this cycle.
  logic rd_fire; // Read address accepted this cycle.
  logic wr_mapped; // Write address hits a writable register.

  // Software-visible control.
  logic done; // Conversion complete flag.
  logic samp; // Sample request.
  logic ten_bit; // Lower resolution mode selected.
  logic [15:0] ctrl_two; // Count, scan and DMA controls.
  logic [15:0] chsel; // Channel zero select.
  logic [15:0] scan_lo; // Scan list, inputs 0 to 15.
  logic [15:0] scan_hi; // Scan list, inputs 16 to 31.
  logic [2:0] amp_en; // Amplifier enables.
  logic [1:0] int_stat; // Sticky event bits.
  logic [1:0] int_mask; // Event enables.

  // Sequencer state.
  adcs_pkg::adcs_state_t state; // Idle or converting.
  logic [4:0] smpi_cnt; // Conversions since the last count event.
  logic [3:0] buf_ptr; // Next result entry.
  logic [4:0] dma_cnt; // Conversions since the last DMA step.
  logic [5:0] scan_pos; // Where the next scan search begins.
  logic [5:0] sel_code; // Code used by the running conversion.
  logic unread; // Entry zero holds a result not yet read.
  logic [11:0] entry [adcs_pkg::NUM_ENTRIES]; // Result storage.

  logic start; // Conversion launched this cycle.
  logic store; // Result arrives this cycle.
  logic reached; // This result completes the programmed count.
  logic dma_mode; // Single-entry mode.
  logic scan_en; // Scan list in use.
  logic [4:0] smpi; // Programmed count minus one.
  logic [5:0] code_now; // Code the next conversion would use.
  logic [1:0] int_set; // Events raised this cycle.
  logic rd_stat; // Status register read this cycle.
  logic rd_entry0; // Entry zero read this cycle.
  logic [31:0] rd_word; // Read data for the address offered.
  logic rd_ok; // Read address is mapped.
  adcs_pkg::adcs_route_t dec_route; // Decoded route of code_now.

  assign dma_mode = ctrl_two[adcs_pkg::CTRL2_DMA_BIT];
  assign scan_en = ctrl_two[adcs_pkg::CTRL2_SCAN_BIT];
  assign smpi = ctrl_two[adcs_pkg::CTRL2_SMPI_LSB +: adcs_pkg::SMPI_W];
  assign wr_fire = aw_got && w_got && !s_axil_bvalid_o;
  assign rd_fire = s_axil_arvalid_i && s_axil_arready_o;
  assign start = (state == adcs_pkg::ST_IDLE) && samp;
  assign store = (state == adcs_pkg::ST_CONVERT) && conv_done_i;
  assign reached = store && (smpi_cnt == smpi);
  assign rd_stat = rd_fire && (s_axil_araddr_i == adcs_pkg::OFF_INT_STAT);
  assign rd_entry0 = rd_fire && (s_axil_araddr_i[7:6] == adcs_pkg::RESULT_PAGE) &&
                     (s_axil_araddr_i[5:2] == 4'h0);
  assign int_set = {store && dma_mode && unread, reached}; // [R1] [R7]
  // Scanning walks the list; otherwise the fixed select is used.
  assign code_now = scan_en ? next_set({32'h0000_0000, scan_hi, scan_lo}, scan_pos) :
                    chsel[adcs_pkg::CHSEL_POS_A_LSB +: 6];

  // Route decoder, registered at conversion start below.
  adcs_input_decode #(
    .SECOND_INSTANCE(SECOND_INSTANCE)
  ) u_decode (
    .code_i(code_now),
    .neg_sel_i(chsel[adcs_pkg::CHSEL_NEG_A_BIT]),
    .amp_en_i(amp_en),
    .ten_bit_i(ten_bit),
    .route_o(dec_route)
  );

  // Write channel handshake; address and data are taken in either order.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axil_awready_o <= 1'b0;
      s_axil_wready_o <= 1'b0;
      s_axil_bvalid_o <= 1'b0;
      s_axil_bresp_o <= adcs_pkg::RESP_OKAY;
    end else begin
      if (!aw_got && !s_axil_bvalid_o && !s_axil_awready_o) begin
        s_axil_awready_o <= 1'b1;
      end
      if (!w_got && !s_axil_bvalid_o && !s_axil_wready_o) begin
        s_axil_wready_o <= 1'b1;
      end
      if (s_axil_awvalid_i && s_axil_awready_o) begin
        aw_got <= 1'b1;
        aw_addr <= s_axil_awaddr_i;
        s_axil_awready_o <= 1'b0;
      end
      if (s_axil_wvalid_i && s_axil_wready_o) begin
        w_got <= 1'b1;
        w_data <= s_axil_wdata_i;
        w_strb <= s_axil_wstrb_i;
        s_axil_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axil_bvalid_o <= 1'b1;
        s_axil_bresp_o <= wr_mapped ? adcs_pkg::RESP_OKAY : adcs_pkg::RESP_SLVERR;
      end
      if (s_axil_bvalid_o && s_axil_bready_i) begin
        s_axil_bvalid_o <= 1'b0;
      end
    end
  end

  // Writable register decode; status, pointers and results are read-only.
  always_comb begin
    unique case (aw_addr)
      adcs_pkg::OFF_CTRL_ONE, adcs_pkg::OFF_CTRL_TWO, adcs_pkg::OFF_CHSEL,
      adcs_pkg::OFF_SCAN_LO, adcs_pkg::OFF_SCAN_HI, adcs_pkg::OFF_AMP,
      adcs_pkg::OFF_INT_MASK: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // Configuration registers written by software.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_two <= adcs_pkg::REG16_RST;
      chsel <= adcs_pkg::REG16_RST;
      scan_lo <= adcs_pkg::REG16_RST;
      scan_hi <= adcs_pkg::REG16_RST;
      amp_en <= adcs_pkg::AMP_RST;
      int_mask <= adcs_pkg::INT_RST;
      ten_bit <= 1'b0;
    end else if (wr_fire) begin
      unique case (aw_addr)
        adcs_pkg::OFF_CTRL_TWO: ctrl_two <= merge16(ctrl_two, w_data, w_strb);
        adcs_pkg::OFF_CHSEL: chsel <= merge16(chsel, w_data, w_strb);
        adcs_pkg::OFF_SCAN_LO: scan_lo <= merge16(scan_lo, w_data, w_strb);
        adcs_pkg::OFF_SCAN_HI: scan_hi <= merge16(scan_hi, w_data, w_strb);
        adcs_pkg::OFF_AMP: if (w_strb[0]) begin
          amp_en <= w_data[2:0];
        end
        adcs_pkg::OFF_INT_MASK: if (w_strb[0]) begin
          int_mask <= w_data[1:0];
        end
        adcs_pkg::OFF_CTRL_ONE: if (w_strb[0]) begin
          ten_bit <= w_data[adcs_pkg::CTRL1_TENBIT_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Sample request: software sets it, launch clears it; a set in the same cycle wins.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      samp <= 1'b0;
    end else if (wr_fire && aw_addr == adcs_pkg::OFF_CTRL_ONE && w_strb[0]) begin
      samp <= w_data[adcs_pkg::CTRL1_SAMP_BIT];
    end else if (start) begin
      samp <= 1'b0;
    end
  end

  // Done flag: completion sets it and beats every clear; launch clears it, and a
  // software write of zero may also clear it before the next sample request.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else if (store) begin
      done <= 1'b1; // [R8]
    end else if (start) begin
      done <= 1'b0; // [R8]
    end else if (wr_fire && aw_addr == adcs_pkg::OFF_CTRL_ONE && w_strb[0] &&
                 !w_data[adcs_pkg::CTRL1_DONE_BIT]) begin
      done <= 1'b0; // Lets polling code clear it just before sampling. [R9]
    end
  end

  // Sequencer: launch on a sample request, wait for the core's result.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= adcs_pkg::ST_IDLE;
      conv_start_o <= 1'b0;
      route_o <= '{kind: adcs_pkg::SRC_NONE, index: 6'h00, neg_input1: 1'b0};
      sel_code <= 6'h00;
    end else begin
      conv_start_o <= 1'b0;
      unique case (state)
        adcs_pkg::ST_IDLE: if (start) begin
          state <= adcs_pkg::ST_CONVERT;
          conv_start_o <= 1'b1;
          route_o <= dec_route; // [R10] [R11] [R12] [R14]
          sel_code <= code_now;
        end
        adcs_pkg::ST_CONVERT: if (conv_done_i) begin
          state <= adcs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Scan position: step past each launched input, restart on the count event.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      scan_pos <= 6'h00;
    end else if (reached || !scan_en) begin
      scan_pos <= 6'h00; // [R2]
    end else if (start) begin
      scan_pos <= code_now + 6'h01;
    end
  end

  // Count of conversions per interrupt event.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      smpi_cnt <= 5'h00;
    end else if (reached) begin
      smpi_cnt <= 5'h00; // [R1]
    end else if (store) begin
      smpi_cnt <= smpi_cnt + 5'h01;
    end
  end

  // Result pointer: sequential in buffer mode, pinned to entry zero in DMA mode.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      buf_ptr <= 4'h0;
    end else if (dma_mode) begin
      buf_ptr <= 4'h0; // [R4]
    end else if (reached) begin
      buf_ptr <= 4'h0; // [R3]
    end else if (store) begin
      buf_ptr <= buf_ptr + 4'h1; // [R15] [R5]
    end
  end

  // Result storage; the slot follows conversion order only, never the input.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < adcs_pkg::NUM_ENTRIES; i++) begin
        entry[i] <= 12'h000;
      end
    end else if (store) begin
      entry[dma_mode ? 4'h0 : buf_ptr] <= conv_result_i; // [R5] [R6] [R7]
    end
  end

  // Unread tracking of entry zero; a new result beats a read in the same cycle.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      unread <= 1'b0;
    end else if (store && dma_mode) begin
      unread <= 1'b1; // [R7]
    end else if (rd_entry0 || !dma_mode) begin
      unread <= 1'b0;
    end
  end

  // DMA address steps once every thirty-two conversions in DMA mode.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      dma_cnt <= 5'h00;
      dma_addr_o <= 16'h0000;
      dma_req_o <= 1'b0;
    end else begin
      dma_req_o <= store && dma_mode;
      if (store && dma_mode) begin
        dma_cnt <= dma_cnt + 5'h01;
        if (dma_cnt == adcs_pkg::DMA_STRIDE_LAST) begin
          dma_addr_o <= dma_addr_o + 16'h0001; // [R4]
        end
      end
    end
  end

  // Sticky status, cleared by reading it; a new event wins over the read.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= adcs_pkg::INT_RST;
      irq_o <= 1'b0;
    end else begin
      int_stat <= (rd_stat ? 2'h0 : int_stat) | int_set; // [R1]
      irq_o <= |(int_stat & int_mask); // [R1]
    end
  end

  // Read data for the offered address; unmapped reads answer zero with an error.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axil_araddr_i[7:6] == adcs_pkg::RESULT_PAGE) begin
      rd_word = {20'h00000, entry[s_axil_araddr_i[5:2]]};
    end else begin
      unique case (s_axil_araddr_i)
        adcs_pkg::OFF_CTRL_ONE: rd_word = {29'h0, ten_bit, samp, done};
        adcs_pkg::OFF_CTRL_TWO: rd_word = {16'h0000, ctrl_two};
        adcs_pkg::OFF_CHSEL: rd_word = {16'h0000, chsel};
        adcs_pkg::OFF_SCAN_LO: rd_word = {16'h0000, scan_lo};
        adcs_pkg::OFF_SCAN_HI: rd_word = {16'h0000, scan_hi};
        adcs_pkg::OFF_AMP: rd_word = {29'h0, amp_en};
        adcs_pkg::OFF_INT_STAT: rd_word = {30'h0, int_stat};
        adcs_pkg::OFF_INT_MASK: rd_word = {30'h0, int_mask};
        adcs_pkg::OFF_DMA_ADDR: rd_word = {16'h0000, dma_addr_o};
        adcs_pkg::OFF_PTR: rd_word = {19'h0, smpi_cnt, 4'h0, buf_ptr};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // Read channel: one read outstanding, answered the cycle after it is taken.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axil_arready_o <= 1'b0;
      s_axil_rvalid_o <= 1'b0;
      s_axil_rdata_o <= 32'h0000_0000;
      s_axil_rresp_o <= adcs_pkg::RESP_OKAY;
    end else begin
      if (!s_axil_rvalid_o && !s_axil_arready_o) begin
        s_axil_arready_o <= 1'b1;
      end
      if (rd_fire) begin
        s_axil_arready_o <= 1'b0;
        s_axil_rvalid_o <= 1'b1;
        s_axil_rdata_o <= rd_word;
        s_axil_rresp_o <= rd_ok ? adcs_pkg::RESP_OKAY : adcs_pkg::RESP_SLVERR;
      end
      if (s_axil_rvalid_o && s_axil_rready_i) begin
        s_axil_rvalid_o <= 1'b0;
      end
    end
  end

  a_start_clears_done: assert property (@(posedge clock_i) disable iff (!rst_n) // [R8]
    conv_start_o |-> !done)
    else $error("done still set after a conversion start");

  a_done_on_result: assert property (@(posedge clock_i) disable iff (!rst_n) // [R8]
    store |=> done && !conv_start_o)
    else $error("done not set on completion");

  a_smpi_flag: assert property (@(posedge clock_i) disable iff (!rst_n) // [R1]
    reached |=> int_stat[adcs_pkg::INT_SMPI_BIT] ##1 (irq_o == int_mask[adcs_pkg::INT_SMPI_BIT]
    || int_stat[adcs_pkg::INT_OVR_BIT] || $past(int_stat[adcs_pkg::INT_OVR_BIT])))
    else $error("count event flag or interrupt missing");

  a_scan_restart: assert property (@(posedge clock_i) disable iff (!rst_n) // [R2]
    reached && scan_en |=> scan_pos == 6'h00)
    else $error("scan list did not restart");

  a_ptr_reset: assert property (@(posedge clock_i) disable iff (!rst_n) // [R3]
    reached && !dma_mode |=> buf_ptr == 4'h0)
    else $error("buffer pointer not returned to first entry");

  a_ptr_step: assert property (@(posedge clock_i) disable iff (!rst_n) // [R15]
    store && !reached && !dma_mode && $stable(ctrl_two) |=> buf_ptr == $past(buf_ptr) + 4'h1)
    else $error("buffer pointer did not step by one");

  a_entry_order: assert property (@(posedge clock_i) disable iff (!rst_n) // [R5]
    store && !dma_mode |=> entry[$past(buf_ptr)] == $past(conv_result_i))
    else $error("result not stored at the sequential entry");

  a_dma_entry0: assert property (@(posedge clock_i) disable iff (!rst_n) // [R7]
    store && dma_mode |=> entry[0] == $past(conv_result_i) && buf_ptr == 4'h0)
    else $error("DMA result not in entry zero");

  a_dma_stride: assert property (@(posedge clock_i) disable iff (!rst_n) // [R4]
    store && dma_mode && dma_cnt != adcs_pkg::DMA_STRIDE_LAST |=> $stable(dma_addr_o))
    else $error("DMA address moved before thirty-two conversions");

  a_temp_route: assert property (@(posedge clock_i) disable iff (!rst_n) // [R11]
    conv_start_o && sel_code == adcs_pkg::CODE_TEMP && !SECOND_INSTANCE
    |-> route_o.kind == adcs_pkg::SRC_TEMP)
    else $error("temperature code not routed to temperature voltage");

  a_neg_route: assert property (@(posedge clock_i) disable iff (!rst_n) // [R10]
    conv_start_o |-> route_o.neg_input1 == $past(chsel[adcs_pkg::CHSEL_NEG_A_BIT]))
    else $error("negative input route does not follow select bit");

endmodule // adcs_top
`default_nettype wire

// ### rtl/adcs_pkg.sv
// Functional notes
// R1 - Count reached sets flag, interrupt when enabled.
// R2 - Scan list restarts when count reached.
// R3 - Non-DMA: buffer pointer returns to first entry.
// R4 - DMA: entry zero only, address steps per 32.
// R5 - Non-DMA: sixteen entries filled sequentially.
// R6 - Entry depends on order, not input.
// R7 - DMA: single entry overwritten, read it first.
// R8 - Done clears at start, sets at completion.
// R9 - Software clears done before setting sample.
// R10 - Negative select: input one or low reference.
// R11 - Positive codes: unconnected, temperature, reserved, inputs.
// R12 - Amplifier codes pick amplifier output when enabled.
// R13 - Second instance: no inputs 32-63, top bits zero.
// R14 - Inputs 32-49 only in ten-bit mode.
// R15 - Non-DMA: pointer steps one per conversion.
`default_nettype none
package adcs_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFF_CHSEL = 8'h08;
  localparam logic [7:0] OFF_SCAN_LO = 8'h0c;
  localparam logic [7:0] OFF_SCAN_HI = 8'h10;
  localparam logic [7:0] OFF_AMP = 8'h14;
  localparam logic [7:0] OFF_INT_STAT = 8'h18;
  localparam logic [7:0] OFF_INT_MASK = 8'h1c;
  localparam logic [7:0] OFF_DMA_ADDR = 8'h20;
  localparam logic [7:0] OFF_PTR = 8'h24;
  localparam logic [1:0] RESULT_PAGE = 2'h1;

  // Field positions.
  localparam int CTRL1_DONE_BIT = 0;
  localparam int CTRL1_SAMP_BIT = 1;
  localparam int CTRL1_TENBIT_BIT = 2;
  localparam int CTRL2_SMPI_LSB = 2;
  localparam int SMPI_W = 5;
  localparam int CTRL2_SCAN_BIT = 10;
  localparam int CTRL2_DMA_BIT = 11;
  localparam int CHSEL_POS_A_LSB = 0;
  localparam int CHSEL_NEG_A_BIT = 7;
  localparam int AMP_OA1_BIT = 0;
  localparam int AMP_OA3_BIT = 1;
  localparam int AMP_OA5_BIT = 2;
  localparam int INT_SMPI_BIT = 0;
  localparam int INT_OVR_BIT = 1;

  // Reset values.
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam logic [2:0] AMP_RST = 3'h0;
  localparam logic [1:0] INT_RST = 2'h0;

  // Sizes and counts.
  localparam int NUM_ENTRIES = 16;
  localparam int RESULT_W = 12;
  localparam logic [4:0] DMA_STRIDE_LAST = 5'h1f;

  // Positive input code map.
  localparam logic [5:0] CODE_UNCONN = 6'h3f;
  localparam logic [5:0] CODE_TEMP = 6'h3e;
  localparam logic [5:0] CODE_RSV_LO = 6'h32;
  localparam logic [5:0] CODE_TENBIT_LO = 6'h20;
  localparam logic [5:0] CODE_AMP5 = 6'h19;
  localparam logic [5:0] CODE_AMP3 = 6'h06;
  localparam logic [5:0] CODE_AMP1 = 6'h03;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // What the sample multiplexer is routed to.
  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_ANALOG = 3'h1,
    SRC_AMP = 3'h2,
    SRC_TEMP = 3'h3,
    SRC_RESERVED = 3'h4
  } adcs_src_t;

  // Route handed to the analog core with each conversion start.
  typedef struct packed {
    adcs_src_t kind;
    logic [5:0] index;
    logic neg_input1;
  } adcs_route_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONVERT = 2'b10
  } adcs_state_t;

endpackage
`default_nettype wire

// ### rtl/adcs_input_decode.sv
`timescale 1ns/10ps
`default_nettype none
// Turns a positive select code into a multiplexer route.
module adcs_input_decode #(
  parameter bit SECOND_INSTANCE = 1'b0
) (
  input wire logic [5:0] code_i,
  input wire logic neg_sel_i,
  input wire logic [2:0] amp_en_i,
  input wire logic ten_bit_i,
  output adcs_pkg::adcs_route_t route_o
);

  logic [5:0] code_eff; // Code after instance masking.

  // Pure decode; the top registers the result.
  always_comb begin
    // The second instance has no upper bank, so the top bit is forced low. [R13]
    code_eff = SECOND_INSTANCE ? {1'b0, code_i[4:0]} : code_i;
    route_o.index = code_eff;
    route_o.neg_input1 = neg_sel_i; // Set picks input one, clear the low reference. [R10]
    if (code_eff == adcs_pkg::CODE_UNCONN) begin
      route_o.kind = adcs_pkg::SRC_NONE; // [R11]
    end else if (code_eff == adcs_pkg::CODE_TEMP) begin
      route_o.kind = adcs_pkg::SRC_TEMP; // [R11]
    end else if (code_eff >= adcs_pkg::CODE_RSV_LO) begin
      route_o.kind = adcs_pkg::SRC_RESERVED; // [R11]
    end else if (code_eff >= adcs_pkg::CODE_TENBIT_LO && !ten_bit_i) begin
      // Upper inputs exist only at the lower resolution. [R14]
      route_o.kind = adcs_pkg::SRC_RESERVED;
    end else if ((code_eff == adcs_pkg::CODE_AMP1 && amp_en_i[adcs_pkg::AMP_OA1_BIT]) ||
                 (code_eff == adcs_pkg::CODE_AMP3 && amp_en_i[adcs_pkg::AMP_OA3_BIT]) ||
                 (code_eff == adcs_pkg::CODE_AMP5 && amp_en_i[adcs_pkg::AMP_OA5_BIT])) begin
      route_o.kind = adcs_pkg::SRC_AMP; // [R12]
    end else begin
      route_o.kind = adcs_pkg::SRC_ANALOG; // [R11] [R12]
    end
  end

endmodule // adcs_input_decode
`default_nettype wire

// ### verif/adcs_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// Analog core stand-in: answers every start after a delay that the bench chooses.
module adcs_core_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [3:0] dly_i,
  input wire logic [11:0] res_i,
  output logic done_o,
  output logic [11:0] result_o
);
  logic [4:0] cnt; // Cycles left before the result is ready.
  // Outside the done pulse the lines carry inverted data, so a late sample is caught.
  assign result_o = done_o ? res_i : ~res_i;
  // One done pulse for each start; a zero delay answers at the first edge after the start is taken.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 5'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt == 5'h01);
      if (start_i) begin
        cnt <= {1'b0, dly_i} + 5'h01;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule // adcs_core_model
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
// Register-level regression of the sequencer through its AXI4-Lite port.
module tb;
  logic clk, rst_n, awv, wv, bry, arv, rry, bv, rv, awr, wrd, arr, st, dn, irq, dq, rq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, rd_v;
  logic [1:0] rresp, rr_v, br, br_v;
  logic [11:0] res, cres;
  logic [3:0] dly;
  logic [15:0] dma_a, dma_o;
  adcs_pkg::adcs_route_t route, rt;
  int n_fail, n_checks;
  logic [5:0] code [7] = '{6'h3f, 6'h3e, 6'h32, 6'h03, 6'h03, 6'h20, 6'h20};
  logic [2:0] kind [7] = '{3'h0, 3'h3, 3'h4, 3'h1, 3'h2, 3'h4, 3'h1};
  adcs_top dut_u (.clock_i(clk), .rst_n_i(rst_n), .s_axil_awaddr_i(awa),
    .s_axil_awvalid_i(awv), .s_axil_awready_o(awr), .s_axil_wdata_i(wd),
    .s_axil_wstrb_i(4'hf), .s_axil_wvalid_i(wv), .s_axil_wready_o(wrd), .s_axil_bresp_o(br),
    .s_axil_bvalid_o(bv), .s_axil_bready_i(bry), .s_axil_araddr_i(ara),
    .s_axil_arvalid_i(arv), .s_axil_arready_o(arr), .s_axil_rdata_o(rdat),
    .s_axil_rresp_o(rresp), .s_axil_rvalid_o(rv), .s_axil_rready_i(rry), .conv_start_o(st),
    .route_o(route), .conv_done_i(dn), .conv_result_i(cres), .dma_addr_o(dma_o),
    .dma_req_o(dq), .irq_o(irq));
  adcs_core_model core_u (.clock_i(clk), .rst_n_i(rst_n), .start_i(st), .dly_i(dly),
    .res_i(res), .done_o(dn), .result_o(cres));
  // Free-running 4 ns clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    br_v = br;
    bry <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rd_v = rdat;
    rr_v = rresp;
    rry <= 1'b0;
  endtask
  // Clearing done together with the sample request avoids a stale done.
  task automatic conv(input logic ten);
    wr(adcs_pkg::OFF_CTRL_ONE, {29'h0, ten, 2'h2});
    do @(posedge clk); while (!st);
    rt = route;
    do @(posedge clk); while (!dn);
    @(posedge clk);
    rq = dq;
    @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // The tests need under 3000 cycles; 10000 means a hang.
  initial begin
    #40000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    {rst_n, awv, wv, bry, arv, rry, awa, ara, wd, dly, res, n_fail, n_checks} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(8'h30);
    chk("unmapped", rr_v, adcs_pkg::RESP_SLVERR);
    wr(adcs_pkg::OFF_INT_STAT, 32'h3);
    chk("ro write", br_v, adcs_pkg::RESP_SLVERR);
    wr(adcs_pkg::OFF_CTRL_TWO, 32'h18);
    wr(adcs_pkg::OFF_INT_MASK, 32'h1);
    // Seven conversions, one count event, a different route each time.
    for (int i = 0; i < 7; i++) begin
      wr(adcs_pkg::OFF_CHSEL, {24'h0, i[0], 1'b0, code[i]});
      wr(adcs_pkg::OFF_AMP, {31'h0, i == 4});
      res <= 12'h111 * i[11:0];
      dly <= i[0] ? 4'h9 : 4'h0;
      conv(i == 6);
      chk("kind", rt.kind, kind[i]);
      chk("neg", rt.neg_input1, i[0]);
      if (kind[i] == 3'h1) chk("index", rt.index, code[i]);
      rd(adcs_pkg::OFF_CTRL_ONE);
      chk("done", rd_v[0], 1'b1);
      chk("no dma req", rq, 1'b0);
    end
    chk("irq", irq, 1'b1);
    rd(adcs_pkg::OFF_PTR);
    chk("ptr", rd_v[3:0], 4'h0);
    for (int i = 0; i < 7; i++) begin
      rd(8'(8'h40 + 4 * i));
      chk("entry", rd_v, 12'h111 * i[11:0]);
    end
    rd(adcs_pkg::OFF_INT_STAT);
    chk("stat", rd_v, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq off", irq, 1'b0);
    wr(adcs_pkg::OFF_CTRL_TWO, 32'h800);
    dma_a = dma_o;
    // Each result is read before the next conversion completes.
    for (int j = 0; j < 32; j++) begin
      res <= j[11:0];
      conv(1'b0);
      rd(8'h40);
      chk("dma entry", rd_v, j);
      chk("dma req", rq, 1'b1);
      if (j == 30) chk("dma hold", dma_o, dma_a);
    end
    chk("dma step", dma_o, 16'(dma_a + 16'h1));
    // Two results with no read between them overrun the single entry.
    conv(1'b0);
    conv(1'b0);
    rd(adcs_pkg::OFF_INT_STAT);
    chk("overrun", rd_v[1], 1'b1);
    // Two conversions per event: the third launch must restart the list, not pick input 9.
    wr(adcs_pkg::OFF_SCAN_LO, 32'h224);
    wr(adcs_pkg::OFF_CTRL_TWO, 32'h404);
    for (int k = 0; k < 3; k++) begin
      conv(1'b0);
      chk("scan", rt.index, k == 1 ? 6'h05 : 6'h02);
    end
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
